// [design/seq_pkg.sv]
// Package with constants and types for the program sequencer
package seq_pkg;
    localparam int PC_W = 12;
    localparam int STACK_DEPTH = 6;
    localparam int PHASES = 4;
    localparam logic [11:0] PC_RESET = 12'h000;
    localparam logic [11:0] VEC_BUS = 12'h004;
    localparam logic [11:0] VEC_EXT = 12'h008;
    localparam logic [11:0] VEC_TMR0 = 12'h00C;
    localparam logic [11:0] VEC_SER0 = 12'h010;
    localparam logic [11:0] VEC_SER1 = 12'h014;
    localparam logic [11:0] VEC_TMR1 = 12'h018;
    localparam int IRQ_N = 6;
    localparam logic [11:0] SKIP_STEP = 12'h002;
    localparam logic [3:0] PHASE_RESET = 4'h1;

    // Operation requested by the execute unit for the current instruction
    typedef enum logic [6:0] {
        OP_SEQ = 7'h01,
        OP_SKIP = 7'h02,
        OP_JUMP = 7'h04,
        OP_CALL = 7'h08,
        OP_RET = 7'h10,
        OP_RETURN_INTERRUPT_OP = 7'h20,
        OP_PCLWR = 7'h40
    } seq_op_t;

    // Command from the execute unit, sampled in the last phase
    typedef struct packed {
        seq_op_t op;
        logic [11:0] target;
        logic [7:0] lowByte;
    } exec_cmd_t;

    // Fetch request toward program memory
    typedef struct packed {
        logic fetch;
        logic [11:0] addr;
    } fetch_req_t;
endpackage : seq_pkg

// [design/program_sequencer_pc_stack.sv]
// Program counter, phase generator and return stack of the controller core
//
// Functional notes
// - System clock split into four one-hot phases; one pass is one cycle.
// - Counter advances at first phase; fetch occurs during that phase.
// - Next fetch overlaps current execution; plain instructions take one cycle.
// - Jumps and calls take two cycles: obtain target, then branch.
// - Twelve-bit counter increments per instruction unless control is redirected.
// - Taken skip discards prefetched instruction and inserts a dummy cycle.
// - Taken skip leaves counter at current address plus two.
// - Low byte writable and readable; upper four bits kept on write.
// - Low byte write inserts one dummy cycle for the new prefetch.
// - Jump or call loads all twelve bits from the instruction field.
// - Six-entry return stack of counter values, hidden from software.
// - Call or interrupt acknowledge pushes the counter onto the stack.
// - Either return pops the newest entry into all counter bits.
// - Reset empties the stack and clears the counter.
// - Vectors: bus controller 004H, external 008H, timer one 00CH.
// - Vectors: serial one 010H, serial two 014H, timer two 018H.
// - Full stack records requests but withholds acknowledge until a return.
// - Calls still execute while the stack is full.
`timescale 1ns/100ps
module program_sequencer_pc_stack #(
    parameter int DEPTH = seq_pkg::STACK_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire seq_pkg::exec_cmd_t execCmd,
    input wire logic skipTaken,
    input wire logic [seq_pkg::IRQ_N-1:0] irqReq,
    output seq_pkg::fetch_req_t fetchReq,
    output logic [3:0] instructionPhases,
    output logic [7:0] pcLowByte,
    output logic [11:0] execAddr,
    output logic execValid,
    output logic [seq_pkg::IRQ_N-1:0] irqAck,
    output logic stackFull
);
    localparam int LW = $clog2(DEPTH + 1);

    // Refuse depths that the pointer width and wrap logic cannot serve
    if (DEPTH < 1 || DEPTH > 15)
    begin : g_depth_check
        $error("DEPTH must be between 1 and 15");
    end

    // Operating notes for whoever wires this block in:
    // - execCmd is only looked at on the last phase of a real slot.
    // - A dummy slot never acts on execCmd, whatever memory shows.
    // - The counter holds the address being fetched, not executed.
    // - Calls push execAddr plus one, which is the counter then.
    // - Interrupts push the counter too, so the dropped word is
    //   fetched again after the return.
    // - Interrupts enter only at the end of plain instructions, so
    //   a branch and its dummy slot are never split apart.
    // - A return on an empty stack keeps the level at zero and
    //   loads a stale entry; software must pair calls and returns.
    // - Stack storage has no reset, saving a wide reset fan-out.
    // - The level saturates at DEPTH while the write index wraps,
    //   so after an overflow the oldest return address is lost.
    // - Requests are sticky; a source cannot withdraw one.
    // - Acknowledge is a one-clock pulse after the accepting edge.

    // Sequencer states: run a fetched instruction or burn a dummy cycle
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_DUMMY = 2'b10
    } seq_state_t;

    // Phase ring and fetch counter
    logic [3:0] phase_ff;
    logic [11:0] pc_ff;
    logic [11:0] nxt_pc;

    // Instruction in execution and its slot type
    logic [11:0] execAddr_ff;
    logic execValid_ff;
    seq_state_t state_ff;
    seq_state_t nxt_state;

    // Return stack; storage is hidden from software
    logic [11:0] stack_ff [DEPTH];
    logic [LW-1:0] level_ff;
    logic [LW-1:0] wrIdx_ff;

    // Interrupt bookkeeping
    logic [seq_pkg::IRQ_N-1:0] pend_ff;
    logic [seq_pkg::IRQ_N-1:0] ack_ff;

    // Decoded strobes; push, pop and take fire on the last phase only, the rest are valid every phase
    logic lastPhase;
    logic full;
    logic doPush;
    logic doPop;
    logic takeIrq;
    logic [11:0] vecAddr;
    logic [seq_pkg::IRQ_N-1:0] grant;
    logic [LW-1:0] popIdx;

    // Priority pick of the lowest-numbered pending request
    function automatic logic [seq_pkg::IRQ_N-1:0] pick_first(
        input logic [seq_pkg::IRQ_N-1:0] req
    );
        logic [seq_pkg::IRQ_N-1:0] g;
        g = '0;
        for (int i = seq_pkg::IRQ_N - 1; i >= 0; i--)
        begin
            if (req[i])
                g = '0;
            if (req[i])
                g[i] = 1'b1;
        end
        return g;
    endfunction : pick_first

    // Vector table, requests ordered bus, ext, tmr0, ser0, ser1, tmr1
    function automatic logic [11:0] vector_of(
        input logic [seq_pkg::IRQ_N-1:0] g
    );
        logic [11:0] v;
        v = seq_pkg::PC_RESET;
        case (1'b1)
            g[0]: v = seq_pkg::VEC_BUS;
            g[1]: v = seq_pkg::VEC_EXT;
            g[2]: v = seq_pkg::VEC_TMR0;
            g[3]: v = seq_pkg::VEC_SER0;
            g[4]: v = seq_pkg::VEC_SER1;
            g[5]: v = seq_pkg::VEC_TMR1;
            default: v = seq_pkg::PC_RESET;
        endcase
        return v;
    endfunction : vector_of

    // Slot end, stack state and request arbitration
    assign lastPhase = phase_ff[seq_pkg::PHASES-1];
    assign full = (level_ff == LW'(DEPTH));
    assign grant = pick_first(pend_ff);
    assign vecAddr = vector_of(grant);
    // Acknowledge withheld while full; the request stays pending
    assign takeIrq = lastPhase && execValid_ff && (|pend_ff) && !full
        && (execCmd.op == seq_pkg::OP_SEQ);
    // Push and pop never meet: one command per slot
    assign doPush = lastPhase && execValid_ff
        && ((execCmd.op == seq_pkg::OP_CALL) || takeIrq);
    assign doPop = lastPhase && execValid_ff && (level_ff != '0)
        && ((execCmd.op == seq_pkg::OP_RET)
        || (execCmd.op == seq_pkg::OP_RETURN_INTERRUPT_OP));
    // Newest entry sits just below the circular write index
    assign popIdx = (wrIdx_ff == '0) ? LW'(DEPTH - 1) : wrIdx_ff - 1'b1;

    // Four one-hot phases rotate every system clock
    always_ff @(posedge sys_clk)
    begin
        // Reset always restarts at the first phase
        if (rst)
            phase_ff <= seq_pkg::PHASE_RESET;
        else
            phase_ff <= {phase_ff[2:0], phase_ff[3]};
    end

    // Next counter and state, decided at the end of execution
    always_comb
    begin
        nxt_pc = pc_ff;
        nxt_state = state_ff;
        if (lastPhase)
        begin
            nxt_state = ST_RUN;
            // Dummy slot or empty pipe: plain step, command ignored
            if (state_ff == ST_DUMMY || !execValid_ff)
                nxt_pc = pc_ff + 12'h001;
            else if (takeIrq)
            begin
                // Vector replaces the prefetched word
                nxt_pc = vecAddr;
                nxt_state = ST_DUMMY;
            end
            else
            begin
                case (execCmd.op)
                    seq_pkg::OP_SEQ: nxt_pc = pc_ff + 12'h001;
                    seq_pkg::OP_SKIP:
                    begin
                        if (skipTaken)
                        begin
                            // Prefetched word is dropped, fetch at +2
                            nxt_pc = execAddr_ff + seq_pkg::SKIP_STEP;
                            nxt_state = ST_DUMMY;
                        end
                        else
                            nxt_pc = pc_ff + 12'h001;
                    end
                    seq_pkg::OP_JUMP, seq_pkg::OP_CALL:
                    begin
                        // Full target comes from the instruction field
                        nxt_pc = execCmd.target;
                        nxt_state = ST_DUMMY;
                    end
                    seq_pkg::OP_RET, seq_pkg::OP_RETURN_INTERRUPT_OP:
                    begin
                        // Return address from the newest entry
                        nxt_pc = stack_ff[popIdx];
                        nxt_state = ST_DUMMY;
                    end
                    seq_pkg::OP_PCLWR:
                    begin
                        // Page kept, only the low byte replaced
                        nxt_pc = {execAddr_ff[11:8], execCmd.lowByte};
                        nxt_state = ST_DUMMY;
                    end
                    default: nxt_pc = pc_ff + 12'h001;
                endcase
            end
        end
    end

    // Counter holds the fetch address; loaded at the phase wrap
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pc_ff <= seq_pkg::PC_RESET;
        else
            pc_ff <= nxt_pc;
    end

    // Sequencer state and the address of the instruction in execution
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_ff <= ST_DUMMY;
            execAddr_ff <= seq_pkg::PC_RESET;
            execValid_ff <= 1'b0;
        end
        else if (lastPhase)
        begin
            // Only the slot-end edge moves the pipeline
            state_ff <= nxt_state;
            // Word fetched this cycle executes next unless it is dropped
            execAddr_ff <= pc_ff;
            execValid_ff <= (nxt_state == ST_RUN);
        end
    end

    // Return stack: circular write index so overflow drops the oldest
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            level_ff <= '0;
            wrIdx_ff <= '0;
        end
        else if (doPush)
        begin
            wrIdx_ff <= (wrIdx_ff == LW'(DEPTH - 1)) ? '0
                : wrIdx_ff + 1'b1;
            // Saturate so full stays true after an overflow
            if (!full)
                level_ff <= level_ff + 1'b1;
        end
        else if (doPop)
        begin
            wrIdx_ff <= popIdx;
            level_ff <= level_ff - 1'b1;
        end
    end

    // Stack storage has no reset; a return on an empty stack still reads a stale entry
    always_ff @(posedge sys_clk)
    begin
        if (doPush)
            stack_ff[wrIdx_ff[LW-1:0]] <= pc_ff;
    end

    // Pending requests: an asserted request wins over the acknowledge clear
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pend_ff <= '0;
            ack_ff <= '0;
        end
        else
        begin
            pend_ff <= (pend_ff & ~(takeIrq ? grant : '0)) | irqReq;
            ack_ff <= takeIrq ? grant : '0;
        end
    end

    // Port mapping; all outputs but stackFull come straight from flip-flops
    assign fetchReq.fetch = phase_ff[0];
    assign fetchReq.addr = pc_ff;
    assign instructionPhases = phase_ff;
    assign pcLowByte = execAddr_ff[7:0];
    assign execAddr = execAddr_ff;
    assign execValid = execValid_ff;
    assign irqAck = ack_ff;
    assign stackFull = full;
endmodule : program_sequencer_pc_stack

// [testbench/program_sequencer_asserts.sv]
// Port checks for the program sequencer
`timescale 1ns/100ps
module program_sequencer_asserts #(
    parameter int DEPTH = seq_pkg::STACK_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire seq_pkg::exec_cmd_t execCmd,
    input wire logic skipTaken,
    input wire logic [seq_pkg::IRQ_N-1:0] irqReq,
    input wire seq_pkg::fetch_req_t fetchReq,
    input wire logic [3:0] instructionPhases,
    input wire logic [7:0] pcLowByte,
    input wire logic [11:0] execAddr,
    input wire logic execValid,
    input wire logic [seq_pkg::IRQ_N-1:0] irqAck,
    input wire logic stackFull
);
    logic take;
    logic [11:0] pageAddr;
    logic [11:0] expVec;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Command taken at the last phase of a real slot
    assign take = instructionPhases[3] && execValid;
    assign pageAddr = {execAddr[11:8], execCmd.lowByte};
    // Vector implied by a one-hot acknowledge
    always_comb
    begin
        expVec = 12'h000;
        for (int i = 0; i < seq_pkg::IRQ_N; i++)
            if (irqAck[i])
                expVec = 12'((i + 1) * 4);
    end
    a_phase_rotate: assert property (instructionPhases == 4'h1 |=>
        instructionPhases == 4'h2 ##1 instructionPhases == 4'h4 ##1
        instructionPhases == 4'h8 ##1 instructionPhases == 4'h1)
        else $error("phase order broken");
    a_seq_next: assert property (take && execCmd.op == seq_pkg::OP_SEQ |=>
        irqAck != 6'h00 || execValid && execAddr == $past(execAddr) + 12'h001)
        else $error("plain instruction did not step by one");
    a_branch_load: assert property (take && (execCmd.op == seq_pkg::OP_JUMP
        || execCmd.op == seq_pkg::OP_CALL) |=> !execValid
        && fetchReq.addr == $past(execCmd.target) ##4 execValid
        && execAddr == $past(execCmd.target, 5))
        else $error("branch target or dummy slot wrong");
    a_skip_two: assert property (take && execCmd.op == seq_pkg::OP_SKIP
        && skipTaken |=> !execValid ##4 execValid
        && execAddr == $past(execAddr, 5) + 12'h002)
        else $error("taken skip did not land two on");
    a_low_write: assert property (take && execCmd.op == seq_pkg::OP_PCLWR
        |=> !execValid && fetchReq.addr == $past(pageAddr))
        else $error("low byte write left its page");
    a_irq_vector: assert property (irqAck != 6'h00 |->
        $onehot(irqAck) && fetchReq.addr == expVec)
        else $error("acknowledge without its vector");
    a_fetch_phase: assert property (fetchReq.fetch == instructionPhases[0])
        else $error("fetch strobe outside first phase");
    a_full_hold: assert property ($past(stackFull) |-> irqAck == 6'h00)
        else $error("acknowledge while stack full");
    a_reset_state: assert property (disable iff (1'b0) rst |=> !execValid
        && instructionPhases == seq_pkg::PHASE_RESET && !stackFull
        && fetchReq.addr == seq_pkg::PC_RESET)
        else $error("reset state wrong");
    c_call: cover property (take && execCmd.op == seq_pkg::OP_CALL);
    c_full: cover property (stackFull && irqReq != 6'h00);
    c_ack: cover property (irqAck != 6'h00);
endmodule : program_sequencer_asserts
bind program_sequencer_pc_stack program_sequencer_asserts #(.DEPTH(DEPTH))
    u_program_sequencer_asserts (.sys_clk(sys_clk), .rst(rst),
    .execCmd(execCmd), .skipTaken(skipTaken), .irqReq(irqReq),
    .fetchReq(fetchReq), .instructionPhases(instructionPhases),
    .pcLowByte(pcLowByte), .execAddr(execAddr), .execValid(execValid),
    .irqAck(irqAck), .stackFull(stackFull));

// [testbench/program_memory_model.sv]
// Program memory model feeding the sequencer its executing word
`timescale 1ns/100ps
module program_memory_model (
    input wire logic sys_clk,
    input wire logic [11:0] execAddr,
    input wire logic execValid,
    output seq_pkg::exec_cmd_t execCmd,
    output logic skipTaken
);
    localparam seq_pkg::exec_cmd_t IDLE = '{seq_pkg::OP_SEQ, 12'h000, 8'h00};
    seq_pkg::exec_cmd_t mem [logic [11:0]];
    seq_pkg::exec_cmd_t word;
    // Skip outcome rides in bit 0 of the word's low byte
    // Dummy slots show a scrambled jump, so acting on one goes astray
    always @(posedge sys_clk)
    begin
        #1;
        if (!execValid)
            word = '{seq_pkg::OP_JUMP, ~execCmd.target, ~execCmd.lowByte};
        else
            word = mem.exists(execAddr) ? mem[execAddr] : IDLE;
        execCmd <= word;
        skipTaken <= word.lowByte[0];
    end
endmodule : program_memory_model

// [testbench/program_sequencer_pc_stack_tb.sv]
// Self-checking bench for the program sequencer and return stack
`timescale 1ns/100ps
module program_sequencer_pc_stack_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] irqReq = 6'h00;
    logic [7:0] rnd = 8'h45;
    logic [11:0] page;
    logic [11:0] expAddr;
    logic [11:0] expQ [$];
    int num_errors = 0;
    int check_count = 0;
    seq_pkg::exec_cmd_t execCmd;
    logic skipTaken;
    seq_pkg::fetch_req_t fetchReq;
    logic [3:0] instructionPhases;
    logic [7:0] pcLowByte;
    logic [11:0] execAddr;
    logic execValid;
    logic [5:0] irqAck;
    logic stackFull;
    // 200 MHz system clock
    always #2.5 sys_clk = ~sys_clk;
    program_sequencer_pc_stack u_program_sequencer_pc_stack (
        .sys_clk(sys_clk), .rst(rst), .execCmd(execCmd),
        .skipTaken(skipTaken), .irqReq(irqReq), .fetchReq(fetchReq),
        .instructionPhases(instructionPhases), .pcLowByte(pcLowByte),
        .execAddr(execAddr), .execValid(execValid), .irqAck(irqAck),
        .stackFull(stackFull));
    program_memory_model u_program_memory_model (.sys_clk(sys_clk),
        .execAddr(execAddr), .execValid(execValid), .execCmd(execCmd),
        .skipTaken(skipTaken));
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    task automatic put(input logic [11:0] a, input seq_pkg::seq_op_t op,
        input logic [11:0] t, input logic [7:0] b);
        u_program_memory_model.mem[a] = '{op, t, b};
    endtask : put
    // Bounded wait, a period at a time, until all notes are used
    task automatic drain;
        for (int i = 0; i < 400 && expQ.size() != 0; i++)
            #5;
        if (expQ.size() != 0)
        begin
            num_errors++;
            $display("MISMATCH drain expected 0 seen %0d", expQ.size());
        end
    endtask : drain
    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    // Six nested calls fill the stack before requests arrive
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rnd = lfsr(rnd);
        page = {4'h1, 1'b1, rnd[6:4], 4'h0};
        put(12'h000, seq_pkg::OP_JUMP, 12'h100, 8'h00);
        put(12'h100, seq_pkg::OP_SKIP, 12'h000, 8'h01);
        put(12'h102, seq_pkg::OP_SKIP, 12'h000, 8'h00);
        put(12'h103, seq_pkg::OP_PCLWR, 12'h000, page[7:0]);
        put(page, seq_pkg::OP_CALL, 12'h200, 8'h00);
        put(12'h701, seq_pkg::OP_RET, 12'h000, 8'h00);
        put(12'h607, seq_pkg::OP_RET, 12'h000, 8'h00);
        for (int k = 2; k < 7; k++)
        begin
            put(12'(k * 256), seq_pkg::OP_CALL, 12'((k + 1) * 256), 8'h00);
            if (k < 6)
                put(12'(k * 256 + 1), seq_pkg::OP_RET, 12'h000, 8'h00);
        end
        expQ = '{12'h000, 12'h100, 12'h102, 12'h103, page, 12'h200,
            12'h300, 12'h400, 12'h500, 12'h600, 12'h700, 12'h701, 12'h601};
        for (int i = 1; i < 7; i++)
        begin
            put(12'(4 * i), seq_pkg::OP_RETURN_INTERRUPT_OP, 12'h000, 8'h00);
            expQ.push_back(12'(4 * i));
            expQ.push_back(12'h601 + 12'(i));
        end
        for (int k = 5; k > 1; k--)
            expQ.push_back(12'(k * 256 + 1));
        expQ.push_back(page + 12'h001);
        #1 rst = 1'b0;
        for (int i = 0; i < 400 && execAddr !== 12'h700; i++)
            #5;
        if (execAddr !== 12'h700)
        begin
            num_errors++;
            $display("MISMATCH wait execAddr expected 700 seen %h", execAddr);
        end
        irqReq = 6'h3F;
        #5 irqReq = 6'h00;
        drain();
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1 rst = 1'b0;
        expQ.push_back(seq_pkg::PC_RESET);
        drain();
        complete_run();
    end
    // Oldest note against each instruction that really executes
    always @(posedge sys_clk)
    begin
        if (!rst && execValid === 1'b1 && instructionPhases[0] === 1'b1)
        begin
            check_count++;
            expAddr = (expQ.size() != 0) ? expQ.pop_front() : 12'hFFF;
            if (execAddr !== expAddr)
            begin
                num_errors++;
                $display("MISMATCH execAddr expected %h seen %h",
                    expAddr, execAddr);
            end
            if (pcLowByte !== expAddr[7:0])
            begin
                num_errors++;
                $display("MISMATCH pcLowByte expected %h seen %h",
                    expAddr[7:0], pcLowByte);
            end
        end
    end
    // Watchdog well beyond the few hundred cycles the run needs
    initial
    begin
        #20000;
        num_errors++;
        complete_run();
    end
endmodule : program_sequencer_pc_stack_tb
